// ==== hdl/cmar_defs.svh ====
// Offsets, field positions, reset values and fixed codes of the configuration register bank.
// Assumes a 32-bit AHB-Lite slave with one aligned word per register.
`ifndef CMAR_DEFS_SVH
`define CMAR_DEFS_SVH
`define CMAR_OFS_WIN_ADDR   12'h0e0
`define CMAR_OFS_WIN_DATA   12'h0e4
`define CMAR_OFS_MSG_CTRL   12'h0f0
`define CMAR_OFS_MSG_ADDR   12'h0f4
`define CMAR_OFS_MSG_UPPER  12'h0f8
`define CMAR_OFS_MSG_DATA   12'h0fc
`define CMAR_OFS_ERR_HDR    12'h100
`define CMAR_OFS_ERR_STAT   12'h104
`define CMAR_OFS_IRQ_MASK   12'h140
`define CMAR_WIN_ADDR_MASK  32'h8fff_ffff
`define CMAR_WIN_EN_BIT     31
`define CMAR_MSI_CAP_ID     8'h05
`define CMAR_MSI_NEXT       8'h00
`define CMAR_MSI_EN_BIT     16
`define CMAR_MME_LSB        20
`define CMAR_MMC_RESET      3'h0
`define CMAR_MME_MAX        3'h5
`define CMAR_ADDR_LO_MASK   32'hffff_fffc
`define CMAR_DATA_MASK      32'h0000_ffff
`define CMAR_ERR_CAP_ID     16'h0001
`define CMAR_ERR_VERSION    4'h1
`define CMAR_ERR_NEXT       12'h150
`define CMAR_ERR_STAT_MASK  32'h001f_f011
`endif

// ==== hdl/cmar_pkg.sv ====
// Types shared by the configuration register bank.
// Assumes the constants header is included alongside.
package cmar_pkg;
    typedef struct packed {
        logic [11:0] addr;
        logic        write;
        logic        valid;
    } cmar_req_t;

    typedef struct packed {
        logic        enable;
        logic [7:0]  bus;
        logic [4:0]  device;
        logic [2:0]  func;
        logic [3:0]  extReg;
        logic [7:0]  regNum;
    } cmar_win_t;

    typedef enum logic [1:0] {
        CMAR_IDLE = 2'b01,
        CMAR_DATA = 2'b10
    } cmar_state_t;
endpackage : cmar_pkg

// ==== hdl/cmar_bank.sv ====
// Configuration register bank: extended access window, message interrupt capability,
// error-reporting header and uncorrectable status, reached over AHB-Lite.
// Assumes a single-master AHB-Lite bus on sys_clk; fault inputs are synchronous pulses.
`include "cmar_defs.svh"
module cmar_bank (
    input  wire logic                sys_clk,
    input  wire logic                reset_n,
    input  wire logic                hotReset_n,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic [31:0]              hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    input  wire logic [20:0]         faultPulse,
    input  wire logic                intxRequest,
    output logic                     legacyIntx,
    output logic                     messageRequest,
    output cmar_pkg::cmar_win_t      windowCfg,
    output logic [31:0]              windowData,
    output logic                     irq
);
    import cmar_pkg::*;

    logic        rstSync1_q;
    logic        rstSync2_q;
    logic        hotSync1_q;
    logic        hotSync2_q;
    cmar_req_t   req_q;
    cmar_state_t state_q;
    logic [31:0] winAddr_q;
    logic [31:0] winData_q;
    logic        msiEn_q;
    logic [2:0]  mme_q;
    logic [31:0] addrLo_q;
    logic [31:0] addrHi_q;
    logic [31:0] msgData_q;
    logic [31:0] errStat_q;
    logic [31:0] irqMask_q;
    logic [31:0] errStat_d;
    logic [31:0] rdData;
    logic        wrStrobe;
    logic        prevIntx_q;

    // Power-on reset released through two flops
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstSync1_q <= 1'b0;
            rstSync2_q <= 1'b0;
        end else begin
            rstSync1_q <= 1'b1;
            rstSync2_q <= rstSync1_q;
        end
    end

    // Hot reset comes from the link side, so it is synchronised as a level
    always_ff @(posedge sys_clk or negedge rstSync2_q) begin
        if (!rstSync2_q) begin
            hotSync1_q <= 1'b0;
            hotSync2_q <= 1'b0;
        end else begin
            hotSync1_q <= hotReset_n;
            hotSync2_q <= hotSync1_q;
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] mask);
        merge = (old & ~mask) | (nw & mask);
    endfunction : merge

    // Write strobe for one register, decoded in the data phase
    function automatic logic wrHit(input cmar_req_t req, input logic [11:0] ofs);
        wrHit = req.valid && req.write && (req.addr == ofs);
    endfunction : wrHit

    // Address phase captured; a write lands at the end of its first data-phase cycle
    always_ff @(posedge sys_clk or negedge rstSync2_q) begin
        if (!rstSync2_q) begin
            req_q   <= '0;
            state_q <= CMAR_IDLE;
        end else begin
            req_q.valid <= hsel && hready && htrans[1];
            req_q.write <= hwrite;
            req_q.addr  <= haddr[11:0];
            state_q     <= (hsel && hready && htrans[1]) ? CMAR_DATA : CMAR_IDLE;
        end
    end

    assign wrStrobe = req_q.valid && req_q.write;

    // Read value assembly; unmapped addresses read zero with OKAY
    always_comb begin
        rdData = 32'h0000_0000;
        // Decoded from the address phase so that hrdata is a flop during the data phase
        unique case (haddr[11:0])
            `CMAR_OFS_WIN_ADDR:  rdData = winAddr_q;
            `CMAR_OFS_WIN_DATA:  rdData = winData_q;
            `CMAR_OFS_MSG_CTRL:  rdData = {8'h00, 1'b1, mme_q, `CMAR_MMC_RESET, msiEn_q,
                                           `CMAR_MSI_NEXT, `CMAR_MSI_CAP_ID};
            `CMAR_OFS_MSG_ADDR:  rdData = addrLo_q;
            `CMAR_OFS_MSG_UPPER: rdData = addrHi_q;
            `CMAR_OFS_MSG_DATA:  rdData = msgData_q;
            `CMAR_OFS_ERR_HDR:   rdData = {`CMAR_ERR_NEXT, `CMAR_ERR_VERSION,
                                           `CMAR_ERR_CAP_ID};
            `CMAR_OFS_ERR_STAT:  rdData = errStat_q;
            `CMAR_OFS_IRQ_MASK:  rdData = irqMask_q;
            default:             rdData = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstSync2_q) begin
        if (!rstSync2_q) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            // One wait state after a write, so a following read sees the new value
            hreadyout <= !(hsel && hready && htrans[1] && hwrite);
            hresp     <= 1'b0;
            if (hsel && hready && htrans[1] && !hwrite) begin
                hrdata <= rdData;
            end
        end
    end

    // Window address: hot reset returns it to its default
    always_ff @(posedge sys_clk or negedge rstSync2_q) begin
        if (!rstSync2_q) begin
            winAddr_q <= 32'h0000_0000;
        end else if (!hotSync2_q) begin
            winAddr_q <= 32'h0000_0000;
        end else if (wrHit(req_q, `CMAR_OFS_WIN_ADDR)) begin
            winAddr_q <= merge(winAddr_q, hwdata, `CMAR_WIN_ADDR_MASK);
        end
    end

    // Window data
    always_ff @(posedge sys_clk or negedge rstSync2_q) begin
        if (!rstSync2_q) begin
            winData_q <= 32'h0000_0000;
        end else if (!hotSync2_q) begin
            winData_q <= 32'h0000_0000;
        end else if (wrHit(req_q, `CMAR_OFS_WIN_DATA)) begin
            winData_q <= hwdata;
        end
    end

    // Message enable bit
    always_ff @(posedge sys_clk or negedge rstSync2_q) begin
        if (!rstSync2_q) begin
            msiEn_q <= 1'b0;
        end else if (!hotSync2_q) begin
            msiEn_q <= 1'b0;
        end else if (wrHit(req_q, `CMAR_OFS_MSG_CTRL)) begin
            msiEn_q <= hwdata[`CMAR_MSI_EN_BIT];
        end
    end

    // Reserved codes are refused so the field never holds them
    always_ff @(posedge sys_clk or negedge rstSync2_q) begin
        if (!rstSync2_q) begin
            mme_q <= 3'h0;
        end else if (!hotSync2_q) begin
            mme_q <= 3'h0;
        end else if (wrHit(req_q, `CMAR_OFS_MSG_CTRL) &&
                     hwdata[`CMAR_MME_LSB+:3] <= `CMAR_MME_MAX) begin
            mme_q <= hwdata[`CMAR_MME_LSB+:3];
        end
    end

    // Low message address, doubleword aligned
    always_ff @(posedge sys_clk or negedge rstSync2_q) begin
        if (!rstSync2_q) begin
            addrLo_q <= 32'h0000_0000;
        end else if (!hotSync2_q) begin
            addrLo_q <= 32'h0000_0000;
        end else if (wrHit(req_q, `CMAR_OFS_MSG_ADDR)) begin
            addrLo_q <= merge(addrLo_q, hwdata, `CMAR_ADDR_LO_MASK);
        end
    end

    // Upper message address
    always_ff @(posedge sys_clk or negedge rstSync2_q) begin
        if (!rstSync2_q) begin
            addrHi_q <= 32'h0000_0000;
        end else if (!hotSync2_q) begin
            addrHi_q <= 32'h0000_0000;
        end else if (wrHit(req_q, `CMAR_OFS_MSG_UPPER)) begin
            addrHi_q <= hwdata;
        end
    end

    // Message data, low half only
    always_ff @(posedge sys_clk or negedge rstSync2_q) begin
        if (!rstSync2_q) begin
            msgData_q <= 32'h0000_0000;
        end else if (!hotSync2_q) begin
            msgData_q <= 32'h0000_0000;
        end else if (wrHit(req_q, `CMAR_OFS_MSG_DATA)) begin
            msgData_q <= merge(msgData_q, hwdata, `CMAR_DATA_MASK);
        end
    end

    // Interrupt mask keeps its value over hot reset, like the flags it gates
    always_ff @(posedge sys_clk or negedge rstSync2_q) begin
        if (!rstSync2_q) begin
            irqMask_q <= 32'h0000_0000;
        end else if (wrHit(req_q, `CMAR_OFS_IRQ_MASK)) begin
            irqMask_q <= merge(irqMask_q, hwdata, `CMAR_ERR_STAT_MASK);
        end
    end

    // Sticky flags: set wins over a write-one clear; hot reset does not touch them
    always_comb begin
        errStat_d = errStat_q;
        if (wrStrobe && req_q.addr == `CMAR_OFS_ERR_STAT) begin
            errStat_d = errStat_d & ~hwdata;
        end
        errStat_d = (errStat_d | {11'h000, faultPulse}) & `CMAR_ERR_STAT_MASK;
    end

    always_ff @(posedge sys_clk or negedge rstSync2_q) begin
        if (!rstSync2_q) begin
            errStat_q <= 32'h0000_0000;
        end else begin
            errStat_q <= errStat_d;
        end
    end

    // Interrupt routing between the legacy pin and message writes
    always_ff @(posedge sys_clk or negedge rstSync2_q) begin
        if (!rstSync2_q) begin
            legacyIntx     <= 1'b0;
            messageRequest <= 1'b0;
            prevIntx_q     <= 1'b0;
            irq            <= 1'b0;
        end else begin
            prevIntx_q     <= intxRequest;
            legacyIntx     <= !msiEn_q && intxRequest;
            messageRequest <= msiEn_q && intxRequest && !prevIntx_q;
            irq            <= |(errStat_d & irqMask_q);
        end
    end

    always_ff @(posedge sys_clk or negedge rstSync2_q) begin
        if (!rstSync2_q) begin
            windowCfg  <= '0;
            windowData <= 32'h0000_0000;
        end else begin
            windowCfg  <= winAddr_q[`CMAR_WIN_EN_BIT] ? cmar_win_t'({winAddr_q[31],
                          winAddr_q[27:0]}) : '0;
            windowData <= winData_q;
        end
    end

    window_gate_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_q)
        !winAddr_q[31] |=> windowCfg == '0) else $error("window active while disabled");
    win_reserved_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_q)
        winAddr_q[30:28] == 3'h0) else $error("window reserved bits set");
    intx_legacy_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_q)
        !msiEn_q && intxRequest |=> legacyIntx) else $error("legacy pin missed");
    intx_ignored_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_q)
        msiEn_q |=> !legacyIntx) else $error("legacy pin while messages on");
    mme_legal_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_q)
        mme_q <= 3'h5) else $error("reserved vector code stored");
    addr_align_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_q)
        addrLo_q[1:0] == 2'h0) else $error("message address unaligned");
    data_upper_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_q)
        msgData_q[31:16] == 16'h0000) else $error("message data upper bits set");
    stat_reserved_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_q)
        (errStat_q & ~32'h001f_f011) == 32'h0) else $error("reserved flag set");
    fault_sticky_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_q)
        faultPulse[12] |=> errStat_q[12]) else $error("fault flag not set");
    hot_keeps_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_q)
        !hotSync2_q && !wrStrobe |=> (errStat_q & $past(errStat_q)) == $past(errStat_q))
        else $error("flag lost on hot reset");

    sequence rdAccept_s;
        hsel && hready && htrans[1] && !hwrite;
    endsequence

    sequence ctrlRead_s;
        rdAccept_s ##0 (haddr[11:0] == `CMAR_OFS_MSG_CTRL);
    endsequence

    sequence hdrRead_s;
        rdAccept_s ##0 (haddr[11:0] == `CMAR_OFS_ERR_HDR);
    endsequence

    sequence flagClear_s;
        wrHit(req_q, `CMAR_OFS_ERR_STAT) && hwdata[0] && !faultPulse[0];
    endsequence

    read_data_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_q)
        rdAccept_s |=> hrdata == $past(rdData)) else $error("read data not presented");
    cap_id_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_q)
        ctrlRead_s |=> hrdata[15:0] == {`CMAR_MSI_NEXT, `CMAR_MSI_CAP_ID})
        else $error("capability identifier wrong");
    cap_fixed_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_q)
        ctrlRead_s |=> hrdata[31:23] == 9'h001 && hrdata[19:17] == 3'h0)
        else $error("fixed control bits wrong");
    err_header_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_q)
        hdrRead_s |=> hrdata == {`CMAR_ERR_NEXT, `CMAR_ERR_VERSION, `CMAR_ERR_CAP_ID})
        else $error("error header wrong");
    flag_clear_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_q)
        flagClear_s |=> !errStat_q[0]) else $error("flag not cleared");
    link_flag_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_q)
        faultPulse[4] |=> errStat_q[4]) else $error("link flag not set");
    window_on_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_q)
        winAddr_q[31] |=> windowCfg.enable) else $error("window not enabled");
    win_data_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_q)
        windowData == $past(winData_q)) else $error("window data copy wrong");
    msg_pulse_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_q)
        messageRequest |=> !messageRequest) else $error("message request held");
    write_wait_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_q)
        wrStrobe |-> !hreadyout) else $error("write without wait state");
    resp_okay_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_q)
        !hresp) else $error("error response given");
    data_phase_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_q)
        (state_q == CMAR_DATA) == req_q.valid) else $error("phase tracking lost");
endmodule : cmar_bank

// ==== verification/cmar_core_model.sv ====
// Bridge core model: one-cycle fault event pulses and a level interrupt request.
// Assumes the bench calls its tasks just after a rising edge of sys_clk.
module cmar_core_model (
    input  wire logic   sys_clk,
    output logic [20:0] faultPulse,
    output logic        intxRequest
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        faultPulse  = 21'h0;
        intxRequest = 1'b0;
    end
    // Events last one cycle only; a held pulse would hide a missing clear
    task automatic pulse(input logic [20:0] bits);
        faultPulse <= bits;
        @(posedge sys_clk);
        faultPulse <= 21'h0;
    endtask : pulse
    task automatic setIntx(input logic lvl);
        intxRequest <= lvl;
    endtask : setIntx
endmodule : cmar_core_model

// ==== verification/tb_top.sv ====
// Self-checking bench for the configuration register bank over AHB-Lite.
// Assumes one slave whose hreadyout is hready; the core model drives events.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, reset_n = 1'b0, hotReset_n = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, d, windowData;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2, f;
    logic [11:0] a;
    logic [11:0] addrs [5] = '{12'h0e0, 12'h0e4, 12'h0f4, 12'h0f8, 12'h0fc};
    logic        hreadyout, hresp, legacyIntx, messageRequest, irq, intxRequest;
    logic [20:0] faultPulse;
    cmar_pkg::cmar_win_t windowCfg;
    int fails = 0, num_checks = 0, cyc = 0, n, l;
    always #5 sys_clk = ~sys_clk;
    cmar_bank cmar_bank_inst (.sys_clk(sys_clk), .reset_n(reset_n), .hotReset_n(hotReset_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .faultPulse(faultPulse), .intxRequest(intxRequest),
        .legacyIntx(legacyIntx), .messageRequest(messageRequest), .windowCfg(windowCfg),
        .windowData(windowData), .irq(irq));
    cmar_core_model cmar_core_model_inst (.sys_clk(sys_clk), .faultPulse(faultPulse),
        .intxRequest(intxRequest));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict
    // Address phase held until hready, then data phase held until hready
    task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {20'h0, ad};
        hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer
    task automatic rc(input logic [11:0] ad, input logic [31:0] exp);
        xfer(1'b0, ad, 32'h0);
        chk(rd, exp);
        chk(hresp, 1'b0);
    endtask : rc
    // Bits that survive a write; reserved bits read zero
    function automatic logic [31:0] keep(input logic [11:0] ad, input logic [31:0] wd);
        case (ad)
            12'h0e0: keep = wd & 32'h8fff_ffff;
            12'h0f4: keep = wd & 32'hffff_fffc;
            12'h0fc: keep = wd & 32'h0000_ffff;
            default: keep = wd;
        endcase
    endfunction : keep
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(91));
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rc(12'h0e0, 32'h0);
        rc(12'h0e4, 32'h0);
        rc(12'h0f0, 32'h0080_0005);
        rc(12'h0f4, 32'h0);
        rc(12'h0f8, 32'h0);
        rc(12'h0fc, 32'h0);
        rc(12'h100, 32'h1501_0001);
        rc(12'h104, 32'h0);
        rc(12'h0e8, 32'h0);
        xfer(1'b1, 12'h100, 32'hffff_ffff);
        rc(12'h100, 32'h1501_0001);
        for (int i = 0; i < 40; i++) begin
            a = (i < 2) ? 12'h0e0 : addrs[$urandom_range(4, 0)];
            d = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h7fff_ffff : $urandom();
            xfer(1'b1, a, d);
            rc(a, keep(a, d));
            if (a == 12'h0e0) chk({3'h0, windowCfg}, d[31] ? {3'h0, 1'b1, d[27:0]} : 32'h0);
            if (a == 12'h0e4) chk(windowData, d);
        end
        // Every enable code; reserved codes leave the field alone
        f = 3'h0;
        for (int c = 0; c < 8; c++) begin
            xfer(1'b1, 12'h0f0, {8'hff, 1'b0, c[2:0], 3'h7, c[0], 16'hffff});
            if (c < 6) f = c[2:0];
            rc(12'h0f0, {8'h0, 1'b1, f, 3'h0, c[0], 16'h0005});
        end
        cmar_core_model_inst.setIntx(1'b1);
        n = 0;
        l = 0;
        repeat (5) begin
            @(posedge sys_clk);
            n += (messageRequest === 1'b1);
            l += (legacyIntx !== 1'b0);
        end
        chk(n, 1);
        chk(l, 0);
        cmar_core_model_inst.setIntx(1'b0);
        xfer(1'b1, 12'h0f0, 32'h0);
        cmar_core_model_inst.setIntx(1'b1);
        repeat (3) @(posedge sys_clk);
        chk(legacyIntx, 1'b1);
        cmar_core_model_inst.setIntx(1'b0);
        repeat (3) @(posedge sys_clk);
        chk(legacyIntx, 1'b0);
        // Events are sticky, masked until enabled, cleared only by writing one
        cmar_core_model_inst.pulse(21'h1f_ffff);
        rc(12'h104, 32'h001f_f011);
        chk(irq, 1'b0);
        xfer(1'b1, 12'h140, 32'h0000_1000);
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b1);
        xfer(1'b1, 12'h104, 32'hffe0_0fee);
        rc(12'h104, 32'h001f_f011);
        xfer(1'b1, 12'h104, 32'h0000_1001);
        rc(12'h104, 32'h001f_e010);
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b0);
        hotReset_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        hotReset_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rc(12'h104, 32'h001f_e010);
        rc(12'h0e4, 32'h0);
        xfer(1'b1, 12'h104, 32'h001f_e010);
        rc(12'h104, 32'h0);
        give_verdict();
    end
endmodule : tb_top
